// ==== logic/wtdc_map.svh ====
`ifndef WTDC_MAP_SVH
`define WTDC_MAP_SVH
`define WTDC_AW          32
`define WTDC_DW          32
`define WTDC_D_IDXW      8
`define WTDC_D_IDX_LSB   2
`define WTDC_D_TAG_LSB   10
`define WTDC_D_TAGW      22
`define WTDC_I_IDXW      6
`define WTDC_I_IDX_LSB   4
`define WTDC_I_TAG_LSB   10
`define WTDC_I_TAGW      22
`define WTDC_I_WORDS     4
`define WTDC_BURST_WORDS 4
`define WTDC_BURST_CNTW  2
`endif

// ==== logic/wtdc_pkg.sv ====
package wtdc_pkg;
   typedef enum logic [1:0]
   {
      WTDC_SZ_BYTE = 2'h0,
      WTDC_SZ_HALF = 2'h1,
      WTDC_SZ_WORD = 2'h2
   } wtdc_size_t;

   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic        cached;
      wtdc_size_t  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } wtdc_dreq_t;

   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic        burst;
      logic [3:0]  be;
      logic [31:0] addr;
      logic [31:0] wdata;
   } wtdc_mreq_t;

   typedef enum logic [2:0]
   {
      WTDC_IDLE  = 3'h0,
      WTDC_MERGE = 3'h1,
      WTDC_MEMWR = 3'h2,
      WTDC_DFILL = 3'h3,
      WTDC_UCRD  = 3'h4,
      WTDC_IFILL = 3'h5
   } wtdc_state_t;
endpackage

// ==== logic/wtdc_cache.sv ====
`timescale 1ns/1ps
`include "wtdc_map.svh"
// Functional notes
// RULE1: separate instruction and data arrays; both may be looked up same cycle.
// RULE2: a data access served by the data cache completes in one clock.
// RULE3: cached load hit returns cached word, no memory bus activity.
// RULE4: cached load miss fetches one or four words, fills cache, then resumes.
// RULE5: refill overwrites the indexed entry without any write-back.
// RULE6: uncached load comes from memory; cache neither used nor updated.
// RULE7: cached word store always writes the entry at its index.
// RULE8: partial store hit reads, merges and writes the full word back.
// RULE9: partial store miss leaves the cache untouched.
// RULE10: every cached store is also written to main memory.
// RULE11: uncached store goes to memory only, no lookup, no cache change.
// RULE12: both caches indexed and tagged by physical address.
// RULE13: no hardware init or invalidate sequence; software does that.
// RULE14: instruction lines hold four words per tag, data lines one word.
// RULE15: both caches direct mapped, one tag and data pair per index.
// RULE16: partial store hit costs one extra clock for read and merge.
// RULE17: every entry carries a valid flag; hit needs valid and tag match.
module wtdc_cache
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 burst_fill,
   input  wire logic                 ireq_valid,
   input  wire logic [31:0]          ireq_addr,
   output logic                      iresp_valid,
   output logic [31:0]               iresp_data,
   input  wire wtdc_pkg::wtdc_dreq_t dreq,
   output logic                      dreq_ready,
   output logic                      dresp_valid,
   output logic [31:0]               dresp_data,
   output wtdc_pkg::wtdc_mreq_t      mreq,
   input  wire logic                 mreq_ready,
   input  wire logic                 mresp_valid,
   input  wire logic [31:0]          mresp_data
);
   localparam int DN = 1 << `WTDC_D_IDXW;
   localparam int IN = 1 << `WTDC_I_IDXW;

   // arrays carry no reset: contents are undefined until software initialises them
   logic [31:0]             d_data  [DN];
   logic [`WTDC_D_TAGW-1:0] d_tag   [DN];
   logic                    d_valid [DN];
   logic [31:0]             i_data  [IN][`WTDC_I_WORDS];
   logic [`WTDC_I_TAGW-1:0] i_tag   [IN];
   logic                    i_valid [IN];

   wtdc_pkg::wtdc_state_t state;
   wtdc_pkg::wtdc_dreq_t  held;
   logic [1:0]            fill_cnt;
   logic                  fill_burst;
   logic                  i_pend;
   logic [31:0]           i_addr_h;

   // data-side lookup on the physical address
   wire logic [`WTDC_D_IDXW-1:0] d_idx = dreq.addr[`WTDC_D_IDX_LSB +: `WTDC_D_IDXW]; // see RULE12
   wire logic [`WTDC_D_TAGW-1:0] d_tg  = dreq.addr[`WTDC_D_TAG_LSB +: `WTDC_D_TAGW];
   wire logic d_hit = d_valid[d_idx] && (d_tag[d_idx] == d_tg); // see RULE17 see RULE15
   wire logic is_idle = (state == wtdc_pkg::WTDC_IDLE);
   wire logic take = is_idle && dreq.valid;
   wire logic is_word = (dreq.size == wtdc_pkg::WTDC_SZ_WORD);
   wire logic ld_hit  = take && !dreq.write && dreq.cached && d_hit; // see RULE3
   wire logic wd_st   = take && dreq.write && dreq.cached && is_word;
   wire logic pt_hit  = take && dreq.write && dreq.cached && !is_word && d_hit;

   // byte enables from size and low address bits
   function automatic logic [3:0] be_of(input wtdc_pkg::wtdc_size_t sz, input logic [1:0] a);
      logic [3:0] b;
      b = 4'hF;
      if (sz == wtdc_pkg::WTDC_SZ_BYTE)
         b = 4'h1 << a;
      else if (sz == wtdc_pkg::WTDC_SZ_HALF)
         b = a[1] ? 4'hC : 4'h3;
      return b;
   endfunction

   // the held copy of the request feeds both the merge and the partial memory write
   wire logic [3:0] held_be = be_of(held.size, held.addr[1:0]);
   wire logic [`WTDC_D_IDXW-1:0] h_idx = held.addr[`WTDC_D_IDX_LSB +: `WTDC_D_IDXW];
   wire logic [31:0] old_word = d_data[h_idx];
   logic [31:0] merged;
   always_comb
   begin
      for (int b = 0; b < 4; b++)
         merged[8*b +: 8] = held_be[b] ? held.wdata[8*b +: 8] : old_word[8*b +: 8]; // see RULE8
   end

   // refill addressing: a burst covers the aligned group of four words
   wire logic use_burst = fill_burst && (state == wtdc_pkg::WTDC_DFILL || state == wtdc_pkg::WTDC_IFILL);
   wire logic [31:0] fill_base = (state == wtdc_pkg::WTDC_IFILL) ? {i_addr_h[31:4], 4'h0}
                                : (fill_burst ? {held.addr[31:4], 4'h0} : {held.addr[31:2], 2'h0});
   wire logic [31:0] fill_addr = fill_base + {28'h0, fill_cnt, 2'h0};
   wire logic [`WTDC_D_IDXW-1:0] f_idx = fill_addr[`WTDC_D_IDX_LSB +: `WTDC_D_IDXW];
   // a single-word data refill ends with its first answer
   wire logic last_word = (state == wtdc_pkg::WTDC_IFILL || fill_burst) ? (fill_cnt == 2'h3) : 1'b1;
   wire logic want_word = (state == wtdc_pkg::WTDC_DFILL) && (fill_addr[31:2] == held.addr[31:2]);

   // instruction-side lookup runs in parallel with the data side
   wire logic [`WTDC_I_IDXW-1:0] ii = ireq_addr[`WTDC_I_IDX_LSB +: `WTDC_I_IDXW]; // see RULE1 see RULE12
   wire logic i_hit = i_valid[ii] && (i_tag[ii] == ireq_addr[`WTDC_I_TAG_LSB +: `WTDC_I_TAGW]); // see RULE17
   wire logic [`WTDC_I_IDXW-1:0] hi = i_addr_h[`WTDC_I_IDX_LSB +: `WTDC_I_IDXW];
   // only one fetch miss is remembered; a second one waits until the first line is in
   wire logic i_start = ireq_valid && !i_hit && !i_pend;
   // the instruction refill waits for the data side to be idle, sharing one memory port
   wire logic i_go = is_idle && i_pend && !dreq.valid;

   wire logic mem_ack = mresp_valid && (state == wtdc_pkg::WTDC_MEMWR || state == wtdc_pkg::WTDC_DFILL
                        || state == wtdc_pkg::WTDC_UCRD || state == wtdc_pkg::WTDC_IFILL);

   wtdc_pkg::wtdc_state_t next_state;
   always_comb
   begin
      next_state = state;
      case (state)
         wtdc_pkg::WTDC_IDLE:
            if (pt_hit)
               next_state = wtdc_pkg::WTDC_MERGE; // see RULE16
            else if (take && dreq.write)
               next_state = wtdc_pkg::WTDC_MEMWR; // see RULE10 see RULE11
            else if (take && dreq.cached && !d_hit)
               next_state = wtdc_pkg::WTDC_DFILL; // see RULE4
            else if (take && !dreq.cached)
               next_state = wtdc_pkg::WTDC_UCRD; // see RULE6
            else if (i_go)
               next_state = wtdc_pkg::WTDC_IFILL;
         wtdc_pkg::WTDC_MERGE:
            next_state = wtdc_pkg::WTDC_MEMWR;
         wtdc_pkg::WTDC_MEMWR,
         wtdc_pkg::WTDC_UCRD:
            if (mresp_valid)
               next_state = wtdc_pkg::WTDC_IDLE;
         wtdc_pkg::WTDC_DFILL,
         wtdc_pkg::WTDC_IFILL:
            if (mresp_valid && last_word)
               next_state = wtdc_pkg::WTDC_IDLE;
         default:
            next_state = wtdc_pkg::WTDC_IDLE;
      endcase
   end

   // memory request, registered; one request per access (a burst refill asks once for four words), held until accepted
   wtdc_pkg::wtdc_mreq_t next_mreq;
   always_comb
   begin
      next_mreq = mreq;
      if (mreq.valid && mreq_ready)
         next_mreq.valid = 1'b0;
      if (take && (dreq.write || !d_hit || !dreq.cached) && !pt_hit)
      begin
         next_mreq.valid = 1'b1;
         next_mreq.write = dreq.write;
         next_mreq.burst = dreq.cached && !dreq.write && burst_fill;
         next_mreq.be    = dreq.write ? be_of(dreq.size, dreq.addr[1:0]) : 4'hF;
         next_mreq.addr  = (dreq.cached && !dreq.write && burst_fill) ? {dreq.addr[31:4], 4'h0} : dreq.addr;
         next_mreq.wdata = dreq.wdata;
      end
      else if (state == wtdc_pkg::WTDC_MERGE)
      begin
         next_mreq.valid = 1'b1;
         next_mreq.write = 1'b1;
         next_mreq.burst = 1'b0;
         next_mreq.be    = held_be; // only the stored bytes go to memory
         next_mreq.addr  = held.addr;
         next_mreq.wdata = held.wdata;
      end
      else if (i_go && !take)
      begin
         next_mreq.valid = 1'b1;
         next_mreq.write = 1'b0;
         next_mreq.burst = 1'b1;
         next_mreq.be    = 4'hF;
         next_mreq.addr  = {i_addr_h[31:4], 4'h0};
         next_mreq.wdata = 32'h0;
      end
      else if (mem_ack && !last_word && use_burst)
      begin
         next_mreq.valid = 1'b0;
      end
   end

   // decoded events of the data and instruction paths
   wire logic st_merge  = (state == wtdc_pkg::WTDC_MERGE);
   wire logic st_dfill  = (state == wtdc_pkg::WTDC_DFILL);
   wire logic st_ifill  = (state == wtdc_pkg::WTDC_IFILL);
   wire logic wr_done   = mem_ack && (state == wtdc_pkg::WTDC_MEMWR);
   wire logic uc_done   = mem_ack && (state == wtdc_pkg::WTDC_UCRD);
   wire logic fill_hit  = mem_ack && want_word;
   wire logic fill_step = mem_ack && (st_dfill || st_ifill);
   wire logic i_done    = mem_ack && st_ifill && last_word;
   // load hits answer in one clock; anything that goes to memory answers when memory does
   wire logic next_dresp_valid = ld_hit || wr_done || uc_done || fill_hit; // see RULE2

   // burst mode is latched with the request, so a later change of burst_fill cannot cut a refill short
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state      <= wtdc_pkg::WTDC_IDLE;
         mreq       <= '0;
         dreq_ready <= 1'b0;
         held       <= '0;
         fill_burst <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         mreq       <= next_mreq;
         dreq_ready <= (next_state == wtdc_pkg::WTDC_IDLE);
         if (take)
         begin
            held       <= dreq;
            fill_burst <= burst_fill;
         end
      end
   end

   // the counter restarts when a data request is taken or an instruction refill starts
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         fill_cnt <= 2'h0;
      else if (take || i_go)
         fill_cnt <= 2'h0;
      else if (fill_step)
         fill_cnt <= fill_cnt + 2'h1;
   end

   // stores report completion only once memory has acknowledged the write
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dresp_valid <= 1'b0;
         dresp_data  <= 32'h0;
      end
      else
      begin
         dresp_valid <= next_dresp_valid; // see RULE2
         if (ld_hit)
            dresp_data <= d_data[d_idx]; // see RULE3
         else if (uc_done || fill_hit)
            dresp_data <= mresp_data;
      end
   end

   // instruction side
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         i_pend      <= 1'b0;
         i_addr_h    <= 32'h0;
         iresp_valid <= 1'b0;
         iresp_data  <= 32'h0;
      end
      else
      begin
         if (i_start)
         begin
            i_pend   <= 1'b1;
            i_addr_h <= ireq_addr;
         end
         else if (i_done)
            i_pend <= 1'b0;
         iresp_valid <= ireq_valid && i_hit;
         iresp_data  <= i_data[ii][ireq_addr[3:2]]; // see RULE14
      end
   end

   // array writes; no reset or invalidate sweep exists in hardware
   always_ff @(posedge mclk) // see RULE13
   begin
      if (wd_st)
      begin
         d_data[d_idx]  <= dreq.wdata; // see RULE7
         d_tag[d_idx]   <= d_tg;
         d_valid[d_idx] <= 1'b1;
      end
      else if (st_merge)
         d_data[h_idx] <= merged; // see RULE8
      else if (fill_step && st_dfill)
      begin
         d_data[f_idx]  <= mresp_data; // see RULE5 see RULE14
         d_tag[f_idx]   <= fill_addr[`WTDC_D_TAG_LSB +: `WTDC_D_TAGW];
         d_valid[f_idx] <= 1'b1;
      end
   end

   // an instruction line turns valid only with its last word, so a half-filled line never hits
   always_ff @(posedge mclk)
   begin
      if (fill_step && st_ifill)
      begin
         i_data[hi][fill_cnt] <= mresp_data;
         i_tag[hi]            <= i_addr_h[`WTDC_I_TAG_LSB +: `WTDC_I_TAGW];
         i_valid[hi]          <= last_word;
      end
   end
   // partial misses and uncached accesses never reach the arrays above: see RULE9 see RULE11 see RULE6
endmodule

// ==== sim/wtdc_cache_assertions.sv ====
`timescale 1ns/1ps
module wtdc_cache_chk
(
   input wire logic                 mclk,
   input wire logic                 rst,
   input wire wtdc_pkg::wtdc_dreq_t dreq,
   input wire logic                 dreq_ready,
   input wire logic                 dresp_valid,
   input wire wtdc_pkg::wtdc_mreq_t mreq,
   input wire logic                 mreq_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire acc = dreq.valid && dreq_ready;
   wire ld  = acc && !dreq.write;
   wire st  = acc && dreq.write;
   wire wd  = dreq.size == wtdc_pkg::WTDC_SZ_WORD;
   a_hit_quiet: assert property (ld && dreq.cached ##1 dresp_valid |-> !mreq.valid)
      else $error("load hit touched the memory bus");
   a_mreq_hold: assert property (mreq.valid && !mreq_ready |=> mreq.valid && $stable(mreq))
      else $error("memory request changed before acceptance");
   a_store_thru: assert property (st |-> ##[1:2] mreq.valid && mreq.write)
      else $error("store not written to memory");
   a_word_full: assert property (st && wd && dreq.cached |=>
      mreq.valid && mreq.be == 4'hF && mreq.addr == $past(dreq.addr))
      else $error("word store not issued in full");
   a_uc_load: assert property (ld && !dreq.cached |-> ##[1:2] mreq.valid && !mreq.write && !mreq.burst)
      else $error("uncached load not read from memory");
   a_part_be: assert property (st && !wd |-> ##[1:2] mreq.valid && mreq.be != 4'hF)
      else $error("partial store wrote whole word");
   a_burst_read: assert property (mreq.valid && mreq.burst |-> !mreq.write)
      else $error("burst used for a write");
   a_one_out: assert property (st |=> !dreq_ready)
      else $error("second data request taken during store");
   c_hit: cover property (ld ##1 dresp_valid);
   c_burst: cover property (mreq.valid && mreq.burst && mreq_ready);
   c_partial: cover property (st && !wd);
endmodule

bind wtdc_cache wtdc_cache_chk u_chk
(
   .mclk        (mclk),
   .rst         (rst),
   .dreq        (dreq),
   .dreq_ready  (dreq_ready),
   .dresp_valid (dresp_valid),
   .mreq        (mreq),
   .mreq_ready  (mreq_ready)
);

// ==== sim/wtdc_mem_model.sv ====
`timescale 1ns/1ps
module wtdc_mem_model
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic [3:0]           slow,
   input  wire wtdc_pkg::wtdc_mreq_t mreq,
   output logic                      mreq_ready,
   output logic                      mresp_valid,
   output logic [31:0]               mresp_data
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] a;
   logic [31:0] w;
   int          left;
   int          gap;
   // unwritten words read as a pattern of their own address
   function automatic logic [31:0] rd(logic [31:0] x);
      x = {x[31:2], 2'h0};
      return mem.exists(x) ? mem[x] : {~x[15:0], x[15:0]};
   endfunction
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mreq_ready  <= 1'b0;
         mresp_valid <= 1'b0;
         mresp_data  <= 32'h0;
         left = 0;
      end
      else
      begin
         mreq_ready  <= 1'b0;
         mresp_valid <= 1'b0;
         // idle data toggles so a stale word never looks fresh
         mresp_data  <= ~mresp_data;
         if (left > 0)
         begin
            if (gap > 0)
               gap--;
            else
            begin
               mresp_valid <= 1'b1;
               mresp_data  <= rd(a);
               a = a + 32'h4;
               left--;
               gap = slow;
            end
         end
         else if (mreq.valid && !mreq_ready)
         begin
            mreq_ready <= 1'b1;
            a = mreq.burst ? {mreq.addr[31:4], 4'h0} : mreq.addr;
            left = mreq.burst ? 4 : 1;
            gap = slow;
            w = rd(mreq.addr);
            for (int i = 0; i < 4; i++)
               if (mreq.be[i])
                  w[8*i+:8] = mreq.wdata[8*i+:8];
            if (mreq.write)
               mem[{mreq.addr[31:2], 2'h0}] = w;
         end
      end
   end
endmodule

// ==== sim/wtdc_cache_test.sv ====
`timescale 1ns/1ps
module wtdc_cache_test;
   localparam wtdc_pkg::wtdc_size_t WD = wtdc_pkg::WTDC_SZ_WORD;
   localparam wtdc_pkg::wtdc_size_t HW = wtdc_pkg::WTDC_SZ_HALF;
   localparam wtdc_pkg::wtdc_size_t BY = wtdc_pkg::WTDC_SZ_BYTE;
   typedef struct {logic bf; logic w; logic c; wtdc_pkg::wtdc_size_t sz; logic [31:0] a; logic [31:0] d; int nb;} wtdc_row_t;
   logic                 mclk = 1'b0;
   logic                 rst = 1'b1;
   logic                 burst_fill = 1'b0;
   logic [3:0]           slow = 4'h0;
   wtdc_pkg::wtdc_dreq_t dreq = '0;
   wtdc_pkg::wtdc_mreq_t mreq;
   logic                 dreq_ready;
   logic                 dresp_valid;
   logic [31:0]          dresp_data;
   logic                 mreq_ready;
   logic                 mresp_valid;
   logic [31:0]          mresp_data;
   logic                 iresp_valid;
   logic [31:0]          q;
   int                   error_cnt = 0;
   int                   n_tests = 0;
   int                   n_mreq = 0;
   int                   n_iresp = 0;
   int                   nb;
   int                   t1;
   int                   t2;
   int                   t3;
   // loads carry the expected word in d, stores the write data
   wtdc_row_t rows [17] = '{
      '{0, 0, 1, WD, 32'h100, 32'hFEFF0100, 1},
      '{0, 0, 1, WD, 32'h100, 32'hFEFF0100, 0},
      '{0, 1, 1, WD, 32'h100, 32'h11223344, 1},
      '{0, 0, 1, WD, 32'h100, 32'h11223344, 0},
      '{0, 1, 1, BY, 32'h101, 32'hAAAAAAAA, 1},
      '{0, 0, 1, WD, 32'h100, 32'h1122AA44, 0},
      '{0, 1, 1, HW, 32'h202, 32'hBEEFBEEF, 1},
      '{0, 0, 1, WD, 32'h200, 32'hBEEF0200, 1},
      '{0, 1, 1, WD, 32'h500, 32'hCAFEF00D, 1},
      '{0, 0, 1, WD, 32'h100, 32'h1122AA44, 1},
      '{0, 1, 0, WD, 32'h100, 32'h77777777, 1},
      '{0, 0, 1, WD, 32'h100, 32'h1122AA44, 0},
      '{0, 0, 0, WD, 32'h100, 32'h77777777, 1},
      '{0, 0, 1, WD, 32'h100, 32'h1122AA44, 0},
      '{1, 0, 1, WD, 32'h300, 32'hFCFF0300, 1},
      '{0, 0, 1, WD, 32'h304, 32'hFCFB0304, 0},
      '{0, 0, 1, WD, 32'h30C, 32'hFCF3030C, 0}
   };
   logic [31:0] pre [6] = '{32'h100, 32'h200, 32'h300, 32'h304, 32'h308, 32'h30C};

   wtdc_cache dut (.mclk(mclk), .rst(rst), .burst_fill(burst_fill), .ireq_valid(1'b0), .ireq_addr(32'h0),
      .iresp_valid(iresp_valid), .iresp_data(), .dreq(dreq), .dreq_ready(dreq_ready), .dresp_valid(dresp_valid),
      .dresp_data(dresp_data), .mreq(mreq), .mreq_ready(mreq_ready), .mresp_valid(mresp_valid),
      .mresp_data(mresp_data));
   wtdc_mem_model u_mem (.mclk(mclk), .rst(rst), .slow(slow), .mreq(mreq), .mreq_ready(mreq_ready),
      .mresp_valid(mresp_valid), .mresp_data(mresp_data));

   initial
   begin
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      if (mreq.valid === 1'b1 && mreq_ready === 1'b1)
         n_mreq++;
      if (!rst && iresp_valid !== 1'b0)
         n_iresp++;
   end

   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // cyc counts edges from acceptance to the answer, for latency checks
   task automatic req(input logic w, input logic c, input wtdc_pkg::wtdc_size_t sz, input logic [31:0] a,
                      input logic [31:0] d, output int cyc);
      dreq <= '{1'b1, w, c, sz, a, d};
      for (cyc = -200; cyc < 200; cyc++)
      begin
         @(posedge mclk);
         if (dreq.valid && dreq_ready === 1'b1)
         begin
            dreq.valid <= 1'b0;
            cyc = -1;
         end
         else if (!dreq.valid && dresp_valid === 1'b1)
            break;
      end
      q = dresp_data;
      if (cyc == 200)
      begin
         error_cnt++;
         tally_and_finish();
      end
   endtask

   initial
   begin
      repeat (8) @(posedge mclk);
      check("ready in reset", 32'h0, {31'h0, dreq_ready});
      check("answer in reset", 32'h0, {31'h0, dresp_valid});
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      check("ready after reset", 32'h1, {31'h0, dreq_ready});
      // arrays start undefined, so each used index is first claimed by an aliasing word store
      foreach (pre[i])
         req(1'b1, 1'b1, WD, pre[i] | 32'h8000, 32'h0, t1);
      foreach (rows[i])
      begin
         burst_fill <= rows[i].bf;
         nb = n_mreq;
         req(rows[i].w, rows[i].c, rows[i].sz, rows[i].a, rows[i].d, t1);
         if (!rows[i].w)
            check("load data", rows[i].d, q);
         check("bus count", rows[i].nb, n_mreq - nb);
      end
      slow <= 4'h3;
      req(1'b1, 1'b1, WD, 32'h100, 32'h12345678, t1);
      req(1'b1, 1'b1, BY, 32'h100, 32'h99999999, t2);
      req(1'b1, 1'b1, BY, 32'h600, 32'h99999999, t3);
      check("partial hit latency", t1 + 1, t2);
      check("partial miss latency", t1, t3);
      req(1'b0, 1'b1, WD, 32'h100, 32'h0, t1);
      check("merged word", 32'h12345699, q);
      // a mid-run reset clears the outputs but leaves the arrays alone
      rst <= 1'b1;
      @(posedge mclk);
      check("mreq in reset", 32'h0, {31'h0, mreq.valid});
      check("ready in second reset", 32'h0, {31'h0, dreq_ready});
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      check("ready after second reset", 32'h1, {31'h0, dreq_ready});
      nb = n_mreq;
      req(1'b0, 1'b1, WD, 32'h100, 32'h0, t1);
      check("word kept over reset", 32'h12345699, q);
      check("kept word bus count", 32'h0, n_mreq - nb);
      check("fetch answers", 32'h0, n_iresp);
      tally_and_finish();
   end
endmodule
